// ### cio_pkg.sv
package cio_pkg;
   // Byte offsets of APB registers
   localparam logic [7:0] CIO_DR_OFS = 8'h00;
   localparam logic [7:0] CIO_DM0_OFS = 8'h04;
   localparam logic [7:0] CIO_DM1_OFS = 8'h08;
   localparam logic [7:0] CIO_DM2_OFS = 8'h0C;
   localparam logic [7:0] CIO_BYP_OFS = 8'h10;
   localparam logic [7:0] CIO_BIE_OFS = 8'h14;
   localparam logic [7:0] CIO_SLW_OFS = 8'h18;
   localparam logic [7:0] CIO_IBD_OFS = 8'h1C;
   localparam logic [7:0] CIO_ITL_OFS = 8'h20;
   localparam logic [7:0] CIO_ITH_OFS = 8'h24;
   localparam logic [7:0] CIO_STAT_OFS = 8'h28;
   localparam logic [7:0] CIO_PS_OFS = 8'h2C;
   localparam logic [7:0] CIO_CTL_OFS = 8'h30;
   localparam logic [7:0] CIO_SIO_OFS = 8'h34;
   localparam logic [7:0] CIO_USB_OFS = 8'h38;
   localparam logic [7:0] CIO_OESEL_OFS = 8'h3C;
   localparam logic [7:0] CIO_PIN_OFS = 8'h40;
   localparam logic [7:0] CIO_PIN_END = 8'h5C;
   // USB pin positions in usb register
   localparam int CIO_USB_HI = 7;
   localparam int CIO_USB_LO = 6;
   // Drive modes
   typedef enum logic [2:0] {
      CIO_DM_ANALOG = 3'h0,
      CIO_DM_HIZ = 3'h1,
      CIO_DM_PULLUP = 3'h2,
      CIO_DM_PULLDN = 3'h3,
      CIO_DM_ODLOW = 3'h4,
      CIO_DM_ODHIGH = 3'h5,
      CIO_DM_STRONG = 3'h6,
      CIO_DM_PULLBOTH = 3'h7
   } cio_dm_t;
   // Interrupt types (high bit, low bit)
   localparam logic [1:0] CIO_IT_OFF = 2'h0;
   localparam logic [1:0] CIO_IT_RISE = 2'h1;
   localparam logic [1:0] CIO_IT_FALL = 2'h2;
   localparam logic [1:0] CIO_IT_BOTH = 2'h3;
   localparam logic [31:0] CIO_ZERO = 32'h0;
endpackage

// ### cio_port.sv
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Three-bit mode decodes analog, hiz, pullup, pulldown, od low, od high, strong, both.
// - Driven value is output data bit, or array signal when bypassed, except on USB pins 6,7 outside USB mode, which always drive the data bit.
// - USB pins: 0 strong low; 1 float, resistive high, or strong high.
// - USB drive enable at bit 7,6; pull enable at bits 15,14.
// - In USB mode the USB drive and pull bits have no effect.
// - Port-wide configuration writes never alter USB drive bits.
// - Reset mode is analog high-Z: driver and input buffer both off, except USB pins 6,7 outside USB mode, which drive strong low with input buffer on.
// - Digital high-Z: driver off, input buffer on.
// - Pull modes: resistive in one state, strong in other, input kept.
// - Open-drain modes: float in one state, strong in other, input kept.
// - Strong mode drives both levels.
// - Pull-both mode: resistive high for 1, resistive low for 0.
// - Resistive modes disabled on special pin in regulated output.
// - Port-form registers: one bit per pin.
// - Pin-form registers alias eight port bits per pin.
// - Bidirectional enable picks high-Z input or configured drive, except on USB pins 6,7 outside USB mode, where it has no effect.
// - Sixteen output-enable lines, each routable to any pin.
// - Slew select matters only in strong and open-drain modes.
// - Eight pins feed one port interrupt request.
// - Per-pin interrupt type: rising, falling, both or off.
// - Detected edge sets status bit and asserts request.
// - Edge detection runs regardless of sleep.
// - Port setting selects CMOS or LVTTL threshold.
// - Per-pin input buffer disable works in every mode.
// - Per special pin choice of supply or regulated output level.
// - Special pin pairs share a four-way input reference select.
module cio_port
   import cio_pkg::*;
#(
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Digital array and bidirectional controls
   input wire logic [PINS-1:0] array_data_in,
   input wire logic [15:0] aux_oe_in,
   input wire logic usb_mode_in,
   // Pins
   input wire logic [PINS-1:0] pin_in,
   output logic [PINS-1:0] pin_out,
   output logic [PINS-1:0] pin_oe_out,
   output logic [PINS-1:0] pin_pullup_out,
   output logic [PINS-1:0] pin_pulldn_out,
   output logic [PINS-1:0] pin_ibuf_en_out,
   output logic [PINS-1:0] pin_slow_out,
   output logic [PINS-1:0] pin_reg_level_out,
   output logic pin_lvttl_out,
   output logic [7:0] sio_ref_sel_out,
   // Port interrupt
   output logic port_irq_out
);
   // Whole module state
   typedef struct packed {
      logic [PINS-1:0] dr, dm0, dm1, dm2, byp, bie, slw, ibd, itl, ith;
      logic [PINS-1:0] stat, sync1, sync2, prev;
      logic [1:0] usb_drv, usb_pull;
      logic ctl_lvttl;
      logic [PINS-1:0] sio_reg;
      logic [7:0] sio_ref;
      logic [PINS*4-1:0] oesel;
      logic [31:0] prdata;
      logic pready, pslverr;
      logic [PINS-1:0] o, oe, pu, pd, ibuf, slow;
      logic irq;
   } cio_state_t;

   cio_state_t st, next_st;

   logic acc, wr, rd;
   logic [PINS-1:0] edge_hit, data, oe_sel;
   logic [2:0] pidx;
   assign acc = psel_in && penable_in && !st.pready;
   assign wr = acc && pwrite_in;
   assign rd = acc && !pwrite_in;
   assign pidx = 3'(paddr_in[4:2]);

   // Rising and falling detection on synchronised pins
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         logic [1:0] it;
         it = {st.ith[i], st.itl[i]};
         edge_hit[i] = ((it == CIO_IT_RISE || it == CIO_IT_BOTH) &&
                        st.sync2[i] && !st.prev[i]) ||
                       ((it == CIO_IT_FALL || it == CIO_IT_BOTH) &&
                        !st.sync2[i] && st.prev[i]);
         data[i] = st.byp[i] ? array_data_in[i] : st.dr[i];
         oe_sel[i] = aux_oe_in[st.oesel[i*4 +: 4]];
      end
   end

   // Next-state logic: bus, interrupts and pin decode
   always_comb begin
      next_st = st;
      next_st.sync1 = pin_in;
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      next_st.pready = acc;
      next_st.pslverr = 1'b0;
      next_st.prdata = CIO_ZERO;
      if (acc) begin
         if (paddr_in[1:0] != 2'h0 || paddr_in > CIO_PIN_END)
            next_st.pslverr = 1'b1;
      end
      // Port-form writes; USB bits live elsewhere so never touched
      if (wr) begin
         case (paddr_in)
            CIO_DR_OFS: next_st.dr = pwdata_in[PINS-1:0];
            CIO_DM0_OFS: next_st.dm0 = pwdata_in[PINS-1:0];
            CIO_DM1_OFS: next_st.dm1 = pwdata_in[PINS-1:0];
            CIO_DM2_OFS: next_st.dm2 = pwdata_in[PINS-1:0];
            CIO_BYP_OFS: next_st.byp = pwdata_in[PINS-1:0];
            CIO_BIE_OFS: next_st.bie = pwdata_in[PINS-1:0];
            CIO_SLW_OFS: next_st.slw = pwdata_in[PINS-1:0];
            CIO_IBD_OFS: next_st.ibd = pwdata_in[PINS-1:0];
            CIO_ITL_OFS: next_st.itl = pwdata_in[PINS-1:0];
            CIO_ITH_OFS: next_st.ith = pwdata_in[PINS-1:0];
            CIO_CTL_OFS: next_st.ctl_lvttl = pwdata_in[0];
            CIO_SIO_OFS: begin
               next_st.sio_reg = pwdata_in[PINS-1:0];
               next_st.sio_ref = pwdata_in[15:8];
            end
            CIO_USB_OFS: begin
               next_st.usb_drv = pwdata_in[CIO_USB_HI:CIO_USB_LO];
               next_st.usb_pull = pwdata_in[CIO_USB_HI+8:CIO_USB_LO+8];
            end
            CIO_OESEL_OFS: next_st.oesel = pwdata_in[PINS*4-1:0];
            default: begin
               // Pin form: dr, dm[2:0], byp, bie, slw, ibd
               if (paddr_in >= CIO_PIN_OFS && paddr_in <= CIO_PIN_END) begin
                  next_st.dr[pidx] = pwdata_in[0];
                  next_st.dm0[pidx] = pwdata_in[1];
                  next_st.dm1[pidx] = pwdata_in[2];
                  next_st.dm2[pidx] = pwdata_in[3];
                  next_st.byp[pidx] = pwdata_in[4];
                  next_st.bie[pidx] = pwdata_in[5];
                  next_st.slw[pidx] = pwdata_in[6];
                  next_st.ibd[pidx] = pwdata_in[7];
               end
            end
         endcase
      end
      // Reads; status read clears what it returned
      if (rd) begin
         case (paddr_in)
            CIO_DR_OFS: next_st.prdata[PINS-1:0] = st.dr;
            CIO_DM0_OFS: next_st.prdata[PINS-1:0] = st.dm0;
            CIO_DM1_OFS: next_st.prdata[PINS-1:0] = st.dm1;
            CIO_DM2_OFS: next_st.prdata[PINS-1:0] = st.dm2;
            CIO_BYP_OFS: next_st.prdata[PINS-1:0] = st.byp;
            CIO_BIE_OFS: next_st.prdata[PINS-1:0] = st.bie;
            CIO_SLW_OFS: next_st.prdata[PINS-1:0] = st.slw;
            CIO_IBD_OFS: next_st.prdata[PINS-1:0] = st.ibd;
            CIO_ITL_OFS: next_st.prdata[PINS-1:0] = st.itl;
            CIO_ITH_OFS: next_st.prdata[PINS-1:0] = st.ith;
            CIO_STAT_OFS: begin
               next_st.prdata[PINS-1:0] = st.stat;
               next_st.stat = '0;
            end
            CIO_PS_OFS: next_st.prdata[PINS-1:0] = st.sync2 & st.ibuf;
            CIO_CTL_OFS: next_st.prdata[0] = st.ctl_lvttl;
            CIO_SIO_OFS: next_st.prdata[15:0] = {st.sio_ref, st.sio_reg};
            CIO_USB_OFS: begin
               next_st.prdata[CIO_USB_HI:CIO_USB_LO] = st.usb_drv;
               next_st.prdata[CIO_USB_HI+8:CIO_USB_LO+8] = st.usb_pull;
            end
            CIO_OESEL_OFS: next_st.prdata[PINS*4-1:0] = st.oesel;
            default: begin
               if (paddr_in >= CIO_PIN_OFS && paddr_in <= CIO_PIN_END)
                  next_st.prdata[7:0] = {st.ibd[pidx], st.slw[pidx],
                     st.bie[pidx], st.byp[pidx], st.dm2[pidx],
                     st.dm1[pidx], st.dm0[pidx], st.dr[pidx]};
            end
         endcase
      end
      // Edge events win over the read clear, clock-free of sleep
      next_st.stat = next_st.stat | edge_hit;
      next_st.irq = |next_st.stat;
      // Per-pin drive decode
      for (int i = 0; i < PINS; i++) begin
         cio_dm_t m;
         logic d, reg_lvl;
         m = cio_dm_t'({st.dm2[i], st.dm1[i], st.dm0[i]});
         d = data[i];
         reg_lvl = st.sio_reg[i];
         if (st.bie[i] && !oe_sel[i])
            m = CIO_DM_HIZ;
         next_st.o[i] = d;
         next_st.oe[i] = 1'b0;
         next_st.pu[i] = 1'b0;
         next_st.pd[i] = 1'b0;
         next_st.ibuf[i] = !st.ibd[i];
         next_st.slow[i] = 1'b0;
         case (m)
            CIO_DM_ANALOG: next_st.ibuf[i] = 1'b0;
            CIO_DM_HIZ: ;
            CIO_DM_PULLUP: begin
               next_st.oe[i] = !d;
               next_st.pu[i] = d && !reg_lvl;
            end
            CIO_DM_PULLDN: begin
               next_st.oe[i] = d;
               next_st.pd[i] = !d && !reg_lvl;
            end
            CIO_DM_ODLOW: begin
               next_st.oe[i] = !d;
               next_st.slow[i] = st.slw[i];
            end
            CIO_DM_ODHIGH: begin
               next_st.oe[i] = d;
               next_st.slow[i] = st.slw[i];
            end
            CIO_DM_STRONG: begin
               next_st.oe[i] = 1'b1;
               next_st.slow[i] = st.slw[i];
            end
            CIO_DM_PULLBOTH: begin
               next_st.pu[i] = d && !reg_lvl;
               next_st.pd[i] = !d && !reg_lvl;
            end
            default: ;
         endcase
      end
      // USB-capable pins in I/O mode; these pins have no slew control
      for (int u = 0; u < CIO_USB_HI - CIO_USB_LO + 1; u++) begin
         if (!usb_mode_in) begin
            next_st.oe[CIO_USB_LO+u] = !st.dr[CIO_USB_LO+u] ||
                                       st.usb_drv[u];
            next_st.pu[CIO_USB_LO+u] = st.dr[CIO_USB_LO+u] &&
                                       !st.usb_drv[u] && st.usb_pull[u];
            next_st.pd[CIO_USB_LO+u] = 1'b0;
            next_st.o[CIO_USB_LO+u] = st.dr[CIO_USB_LO+u];
            next_st.ibuf[CIO_USB_LO+u] = !st.ibd[CIO_USB_LO+u];
            next_st.slow[CIO_USB_LO+u] = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in)
         st <= '0;
      else
         st <= next_st;
   end

   // Outputs straight from flops
   assign prdata_out = st.prdata;
   assign pready_out = st.pready;
   assign pslverr_out = st.pslverr;
   assign pin_out = st.o;
   assign pin_oe_out = st.oe;
   assign pin_pullup_out = st.pu;
   assign pin_pulldn_out = st.pd;
   assign pin_ibuf_en_out = st.ibuf;
   assign pin_slow_out = st.slow;
   assign pin_reg_level_out = st.sio_reg;
   assign pin_lvttl_out = st.ctl_lvttl;
   assign sio_ref_sel_out = st.sio_ref;
   assign port_irq_out = st.irq;

   // Assertions
   property p_stat_set;
      @(posedge clk_in) disable iff (reset_in)
      (|edge_hit) |=> (st.stat & $past(edge_hit)) == $past(edge_hit);
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("edge lost");

   property p_irq;
      @(posedge clk_in) disable iff (reset_in)
      (|edge_hit) |=> port_irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("no irq after edge");

   sequence s_stat_read;
      psel_in && penable_in && !pwrite_in && !pready_out &&
      paddr_in == CIO_STAT_OFS && !(|edge_hit);
   endsequence
   property p_clear;
      @(posedge clk_in) disable iff (reset_in)
      s_stat_read |=> st.stat == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("status not cleared");

   property p_analog;
      @(posedge clk_in) disable iff (reset_in)
      ({st.dm2[0], st.dm1[0], st.dm0[0]} == CIO_DM_ANALOG && !st.bie[0]) |=>
         !pin_ibuf_en_out[0] && !pin_oe_out[0];
   endproperty
   a_analog: assert property (p_analog) else $error("analog not off");

   property p_strong;
      @(posedge clk_in) disable iff (reset_in)
      ({st.dm2[0], st.dm1[0], st.dm0[0]} == CIO_DM_STRONG && !st.bie[0])
         |=> pin_oe_out[0];
   endproperty
   a_strong: assert property (p_strong) else $error("strong not driven");

   property p_nopull_reg;
      @(posedge clk_in) disable iff (reset_in)
      st.sio_reg[2] |=> !pin_pullup_out[2] && !pin_pulldn_out[2];
   endproperty
   a_nopull_reg: assert property (p_nopull_reg) else $error("pull in reg");

   property p_apb;
      @(posedge clk_in) disable iff (reset_in)
      (psel_in && penable_in && !pready_out) |=> pready_out;
   endproperty
   a_apb: assert property (p_apb) else $error("apb no answer");

   // Out of range address must come back as an error reply
   property p_refuse;
      @(posedge clk_in) disable iff (reset_in)
      (psel_in && penable_in && !pready_out && paddr_in > CIO_PIN_END) |=>
         pready_out && pslverr_out;
   endproperty
   a_refuse: assert property (p_refuse) else $error("no error reply");

   // Resistive drive never carries the slow edge option
   property p_slew_res;
      @(posedge clk_in) disable iff (reset_in)
      ((pin_pullup_out | pin_pulldn_out) & pin_slow_out) == '0;
   endproperty
   a_slew_res: assert property (p_slew_res) else $error("slow on pull");

   // A disabled input buffer stays off whatever the mode
   property p_ibuf_off;
      @(posedge clk_in) disable iff (reset_in)
      (|st.ibd) |=> ($past(st.ibd) & pin_ibuf_en_out) == '0;
   endproperty
   a_ibuf_off: assert property (p_ibuf_off) else $error("ibuf not off");

   // USB pin with pull only: resistive high for data 1
   property p_usb_pull;
      @(posedge clk_in) disable iff (reset_in)
      (!usb_mode_in && st.dr[CIO_USB_HI] &&
       !st.usb_drv[CIO_USB_HI-CIO_USB_LO] &&
       st.usb_pull[CIO_USB_HI-CIO_USB_LO]) |=>
         pin_pullup_out[CIO_USB_HI] && !pin_oe_out[CIO_USB_HI];
   endproperty
   a_usb_pull: assert property (p_usb_pull) else $error("usb no pull");

   property p_usb_low;
      @(posedge clk_in) disable iff (reset_in)
      (!usb_mode_in && !st.dr[CIO_USB_HI]) |=>
         pin_oe_out[CIO_USB_HI] && !pin_out[CIO_USB_HI];
   endproperty
   a_usb_low: assert property (p_usb_low) else $error("usb not low");
endmodule

// ### cio_pin_partner.sv
`timescale 1ns/1ps
// External circuit on the port pins: a switchable driver plus pin loading
module cio_pin_partner (
   // Clock
   input wire logic clk_in,
   // Device pin controls
   input wire logic [7:0] pin_out_in,
   input wire logic [7:0] pin_oe_in,
   input wire logic [7:0] pin_pullup_in,
   input wire logic [7:0] pin_pulldn_in,
   // Bench controlled external driver
   input wire logic [7:0] ext_en_in,
   input wire logic [7:0] ext_val_in,
   // Resolved pin levels
   output logic [7:0] level_out
);
   logic [7:0] flt = 8'h00;
   // Floating pins wander so a stale level never passes for a drive
   always @(posedge clk_in) begin
      flt <= ~flt;
   end
   // Device strong drive wins, then outside driver, then resistors
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_in[i]) level_out[i] = pin_out_in[i];
         else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
         else if (pin_pullup_in[i]) level_out[i] = 1'h1;
         else if (pin_pulldn_in[i]) level_out[i] = 1'h0;
         else level_out[i] = flt[i];
      end
   end
endmodule

// ### test_configurable_io_port.sv
`timescale 1ns/1ps
module test_configurable_io_port;
   import cio_pkg::*;
   // Clock, reset and bus
   logic clk_in = 1'h0;
   logic reset_in = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, lvttl, irq, err;
   // Pin side
   logic [7:0] array_data = 8'h00;
   logic [15:0] aux_oe = 16'h0000;
   logic usb_mode = 1'h0;
   logic [7:0] ext_en = 8'h0F;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] lvl, pin_out, pin_oe, pin_pu, pin_pd, ibuf, slow, reg_lvl;
   logic [7:0] ref_sel;
   logic [31:0] rd;
   logic [2:0] snap;
   int n_fail = 0;
   int n_checks = 0;

   cio_port i_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .array_data_in(array_data), .aux_oe_in(aux_oe),
      .usb_mode_in(usb_mode), .pin_in(lvl), .pin_out(pin_out),
      .pin_oe_out(pin_oe), .pin_pullup_out(pin_pu), .pin_pulldn_out(pin_pd),
      .pin_ibuf_en_out(ibuf), .pin_slow_out(slow),
      .pin_reg_level_out(reg_lvl), .pin_lvttl_out(lvttl),
      .sio_ref_sel_out(ref_sel), .port_irq_out(irq));
   cio_pin_partner i_ext (.clk_in(clk_in), .pin_out_in(pin_out),
      .pin_oe_in(pin_oe), .pin_pullup_in(pin_pu), .pin_pulldn_in(pin_pd),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

   initial forever #12.5 clk_in = ~clk_in;

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'h1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'h1 && n < 40);
      rd = prdata;
      err = pslverr;
      if (n >= 40) n_fail++;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdc(input string what, input logic [7:0] a,
                      input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(what, e, rd);
   endtask
   // Pin outputs lag the stored setting by one cycle
   task automatic settle;
      repeat (2) @(negedge clk_in);
   endtask
   function automatic logic [2:0] view(input int p);
      return {pin_oe[p], pin_pu[p], pin_pd[p]};
   endfunction
   // Expected {strong, pull-up, pull-down} for a mode and data bit
   function automatic logic [2:0] exp_drv(input logic [2:0] m, input logic d);
      case (m)
         3'h2: return d ? 3'h2 : 3'h4;
         3'h3: return d ? 3'h4 : 3'h1;
         3'h4: return d ? 3'h0 : 3'h4;
         3'h5: return d ? 3'h4 : 3'h0;
         3'h6: return 3'h4;
         3'h7: return d ? 3'h2 : 3'h1;
         default: return 3'h0;
      endcase
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (9) @(posedge clk_in);
      @(negedge clk_in);
      chk("reset pins", 32'h0, {pin_oe, pin_pu, pin_pd, ibuf});
      @(posedge clk_in);
      reset_in <= 1'h0;
      rdc("dm0 reset", CIO_DM0_OFS, 32'h0);
      apb(1'h0, 8'h60, 32'h0);
      chk("unmapped", 32'h1, 32'(err));
      // Every mode with both data levels through pin 2's pin form
      for (int k = 0; k < 16; k++) begin
         wr(8'h48, 32'(k));
         settle();
         snap = exp_drv(3'(k >> 1), k[0]);
         chk("mode view", 32'(snap), 32'(view(2)));
         if (snap[2]) chk("mode data", 32'(k[0]), 32'(pin_out[2]));
         if (k / 2 != 6) chk("ibuf", 32'(k / 2 != 0), 32'(ibuf[2]));
      end
      wr(CIO_SIO_OFS, 32'h0000_A504);
      wr(8'h48, 32'h5);
      settle();
      chk("sio sel", 32'hA504, {16'h0, ref_sel, reg_lvl});
      chk("reg pull", 32'h0, 32'(view(2)));
      wr(CIO_SIO_OFS, 32'h0);
      // Port form reaches several pins; USB drive bits stay put
      wr(CIO_USB_OFS, 32'h80);
      wr(CIO_DR_OFS, 32'h15);
      wr(CIO_DM0_OFS, 32'h00);
      wr(CIO_DM1_OFS, 32'hFF);
      wr(CIO_DM2_OFS, 32'hFF);
      settle();
      chk("port oe", 32'h3F, 32'(pin_oe[5:0]));
      chk("port data", 32'h15, 32'(pin_out[5:0]));
      rdc("pin form", 8'h40, 32'h0D);
      rdc("usb kept", CIO_USB_OFS, 32'h80);
      wr(8'h40, 32'h1C);
      @(posedge clk_in);
      array_data <= 8'h01;
      settle();
      chk("bypass", 32'h1, 32'(pin_out[0]));
      // USB pin 7 in I/O mode: every data, pull and drive mix
      for (int k = 0; k < 8; k++) begin
         wr(CIO_DR_OFS, 32'(k[2]) << 7);
         wr(CIO_USB_OFS, (32'(k[1]) << 15) | (32'(k[0]) << 7));
         settle();
         snap = (!k[2] || k[0]) ? 3'h4 : (k[1] ? 3'h2 : 3'h0);
         chk("usb view", 32'(snap), 32'(view(7)));
         if (snap[2]) chk("usb data", 32'(k[2]), 32'(pin_out[7]));
      end
      @(posedge clk_in);
      usb_mode <= 1'h1;
      wr(CIO_USB_OFS, 32'h0);
      settle();
      snap = view(7);
      wr(CIO_USB_OFS, 32'hC0C0);
      settle();
      chk("usb mode", 32'(snap), 32'(view(7)));
      // Pin 1 bidirectional on aux line 15, slow strong drive
      wr(CIO_OESEL_OFS, 32'hF0);
      wr(8'h44, 32'h6D);
      settle();
      chk("bidir in", 32'h1, 32'({pin_oe[1], ibuf[1]}));
      @(posedge clk_in);
      aux_oe <= 16'h7FFF;
      settle();
      chk("other line", 32'h0, 32'(pin_oe[1]));
      @(posedge clk_in);
      aux_oe <= 16'h8000;
      settle();
      chk("bidir out", 32'h3, 32'({pin_oe[1], slow[1]}));
      wr(8'h44, 32'hED);
      settle();
      chk("ibuf off", 32'h0, 32'(ibuf[1]));
      wr(CIO_CTL_OFS, 32'h1);
      settle();
      chk("lvttl", 32'h1, 32'(lvttl));
      // Edges: pin 0 rising, 1 falling, 2 both, 3 off
      wr(CIO_DM0_OFS, 32'hFF);
      wr(CIO_DM1_OFS, 32'h0);
      wr(CIO_DM2_OFS, 32'h0);
      wr(CIO_ITL_OFS, 32'h05);
      wr(CIO_ITH_OFS, 32'h06);
      @(posedge clk_in);
      ext_val <= 8'h0F;
      repeat (8) @(negedge clk_in);
      chk("irq set", 32'h1, 32'(irq));
      rdc("rise stat", CIO_STAT_OFS, 32'h05);
      rdc("stat read", CIO_STAT_OFS, 32'h0);
      apb(1'h0, CIO_PS_OFS, 32'h0);
      // Pin 1 still has its input buffer switched off
      chk("pin state", 32'hD, 32'(rd[3:0]));
      settle();
      chk("irq clr", 32'h0, 32'(irq));
      @(posedge clk_in);
      ext_val <= 8'h00;
      repeat (8) @(negedge clk_in);
      rdc("fall stat", CIO_STAT_OFS, 32'h06);
      stop_test();
   end

   // Whole run is well under two thousand cycles
   initial begin
      repeat (5000) @(posedge clk_in);
      n_fail++;
      stop_test();
   end
endmodule
